// ===== src/core_register_slave_port.sv
`timescale 1ns/1ps
// What this block does
// - Decodes the core register window, serving every master except the processor.
// - First attempt into the window is answered with retry, freeing the bus.
// - Then injects one pipeline operation performing the read or write.
// - Master repeats; every repeat is retried until the processor returns data.
// - Unimplemented register: processor never acknowledges, so retries continue forever.
module crsp_core_register_slave_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic busReq,
    input wire logic busFromCore,
    input wire logic busWrite,
    input wire logic [31:0] busAddr,
    input wire logic [31:0] busWdata,
    output logic [1:0] busAck,
    output logic [31:0] busRdata,
    output logic injValid,
    output logic injWrite,
    output logic [15:0] injAddr,
    output logic [31:0] injWdata,
    input wire logic injReady,
    input wire logic coreDone,
    input wire logic [31:0] coreRdata
);
    logic hit;
    logic take;
    logic sameReq;
    logic injPend_r;
    logic [31:0] addr_r;
    logic write_r;
    logic [31:0] rdata_r;
    logic [1:0] ack_r;
    logic [31:0] busWdataHeld;
    crsp_pkg::crsp_state_t state_r;

    crsp_window_decode uDec (
        .addr(busAddr),
        .fromCore(busFromCore),
        .hit(hit)
    );

    assign take = clkEn && busReq && hit;
    assign sameReq = busAddr == addr_r && busWrite == write_r;

    // A repeat must match address and direction to collect the result.
    // Any other attempt is retried, so it cannot steal a finished operation.
    // Only one operation is outstanding; the cost is that other masters wait.
    // Retry first, retry repeats, then acknowledge.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= crsp_pkg::S_IDLE;
            ack_r <= crsp_pkg::ACK_NONE;
            addr_r <= 32'h0000_0000;
            write_r <= 1'b0;
        end else if (clkEn) begin
            ack_r <= crsp_pkg::ACK_NONE;
            case (state_r)
                crsp_pkg::S_IDLE: begin
                    if (take) begin
                        ack_r <= crsp_pkg::ACK_RETRY;
                        addr_r <= busAddr;
                        write_r <= busWrite;
                        state_r <= crsp_pkg::S_WAIT;
                    end
                end
                crsp_pkg::S_WAIT: begin
                    if (take) begin
                        ack_r <= crsp_pkg::ACK_RETRY;
                    end
                    if (coreDone && !injPend_r) begin
                        state_r <= crsp_pkg::S_DONE;
                    end
                end
                crsp_pkg::S_DONE: begin
                    if (take && sameReq) begin
                        ack_r <= crsp_pkg::ACK_OK;
                        state_r <= crsp_pkg::S_IDLE;
                    end else if (take) begin
                        ack_r <= crsp_pkg::ACK_RETRY;
                    end
                end
                default: state_r <= crsp_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            injPend_r <= 1'b0;
        end else if (clkEn) begin
            if (state_r == crsp_pkg::S_IDLE && take) begin
                injPend_r <= 1'b1;
            end else if (injReady) begin
                injPend_r <= 1'b0;
            end
        end
    end

    // A completion seen while the injection is still pending is ignored.
    // The pipeline cannot have run an operation that it has not yet accepted.
    // Capture read data.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (clkEn && state_r == crsp_pkg::S_WAIT && coreDone && !injPend_r) begin
            rdata_r <= write_r ? 32'h0000_0000 : coreRdata;
        end
    end

    assign busAck = ack_r;
    // Read data shows only with the normal acknowledge, so no stale value leaks.
    assign busRdata = (ack_r == crsp_pkg::ACK_OK) ? rdata_r : 32'h0000_0000;
    assign injValid = injPend_r;
    assign injWrite = write_r;
    assign injAddr = addr_r[15:0];
    assign injWdata = busWdataHeld;

    // Write data held.
    // The master may change its data between attempts, so the first one is kept.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busWdataHeld <= 32'h0000_0000;
        end else if (clkEn && state_r == crsp_pkg::S_IDLE && take) begin
            busWdataHeld <= busWdata;
        end
    end

    a_first_retry: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && state_r == crsp_pkg::S_IDLE && take |=> busAck == crsp_pkg::ACK_RETRY)
        else $error("first access not retried");

    a_inject_after: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && state_r == crsp_pkg::S_IDLE && take |=> injValid)
        else $error("no injection after retry");

    a_wait_retry: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && state_r == crsp_pkg::S_WAIT && take |=> busAck == crsp_pkg::ACK_RETRY)
        else $error("repeat not retried while waiting");

    a_no_early_ok: assert property (@(posedge clk) disable iff (!reset_n)
        busAck == crsp_pkg::ACK_OK |-> $past(state_r) == crsp_pkg::S_DONE)
        else $error("ok without completion");

    a_ok_data: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && state_r == crsp_pkg::S_DONE && take && sameReq
        |=> busAck == crsp_pkg::ACK_OK && state_r == crsp_pkg::S_IDLE)
        else $error("completed repeat not acknowledged");

    a_core_excluded: assert property (@(posedge clk) disable iff (!reset_n)
        busReq && busFromCore && state_r == crsp_pkg::S_IDLE && clkEn
        |=> busAck == crsp_pkg::ACK_NONE)
        else $error("processor access served");

    a_outside_window: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && busReq && busAddr < crsp_pkg::WIN_LO |=> busAck == crsp_pkg::ACK_NONE)
        else $error("outside window answered");

    a_freeze: assert property (@(posedge clk) disable iff (!reset_n)
        !clkEn |=> $stable(state_r))
        else $error("state moved while disabled");

    a_inject_held: assert property (@(posedge clk) disable iff (!reset_n)
        injValid && !injReady |=> injValid && $stable(injAddr) && $stable(injWdata))
        else $error("injection changed before acceptance");

    a_single_inject: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && injValid && injReady |=> !injValid)
        else $error("injection repeated after acceptance");

    a_wait_no_ok: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == crsp_pkg::S_WAIT |=> busAck != crsp_pkg::ACK_OK)
        else $error("ok while operation outstanding");

    a_reserved_wait: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == crsp_pkg::S_WAIT && !coreDone |=> state_r == crsp_pkg::S_WAIT)
        else $error("left wait without completion");

    a_ok_to_idle: assert property (@(posedge clk) disable iff (!reset_n)
        busAck == crsp_pkg::ACK_OK |-> state_r == crsp_pkg::S_IDLE)
        else $error("ok given but operation kept");

    a_rdata_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        busAck != crsp_pkg::ACK_OK |-> busRdata == 32'h0000_0000)
        else $error("read data shown without ok");

    a_ack_needs_take: assert property (@(posedge clk) disable iff (!reset_n)
        $past(clkEn) && busAck != crsp_pkg::ACK_NONE |-> $past(take))
        else $error("answer without attempt");

    a_no_error: assert property (@(posedge clk) disable iff (!reset_n)
        busAck != crsp_pkg::ACK_ERR)
        else $error("error acknowledge given");

    a_done_hold: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && state_r == crsp_pkg::S_DONE && !take |=> state_r == crsp_pkg::S_DONE)
        else $error("finished result dropped");

    c_retry: cover property (@(posedge clk) busAck == crsp_pkg::ACK_RETRY);
    c_ok: cover property (@(posedge clk) busAck == crsp_pkg::ACK_OK);
    c_inject: cover property (@(posedge clk) injValid && injReady);
    c_done: cover property (@(posedge clk) state_r == crsp_pkg::S_DONE);
    c_freeze: cover property (@(posedge clk) !clkEn && busReq);
endmodule

// ===== src/crsp_pkg.sv
package crsp_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // Core register window bounds.
    localparam logic [31:0] WIN_LO = 32'hF7E1_0000;
    localparam logic [31:0] WIN_HI = 32'hF7E1_FFFF;
    // Bus acknowledge codes.
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [1:0] ACK_OK = 2'h1;
    localparam logic [1:0] ACK_RETRY = 2'h2;
    localparam logic [1:0] ACK_ERR = 2'h3;
    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_WAIT = 3'h2,
        S_DONE = 3'h4
    } crsp_state_t;
endpackage

// ===== src/crsp_window_decode.sv
`timescale 1ns/1ps
module crsp_window_decode (
    input wire logic [31:0] addr,
    input wire logic fromCore,
    output logic hit
);
    assign hit = !fromCore && addr >= crsp_pkg::WIN_LO && addr <= crsp_pkg::WIN_HI;
endmodule

// ===== tb/crsp_core_model.sv
`timescale 1ns/1ps
module crsp_core_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic injValid,
    input wire logic injWrite,
    input wire logic [15:0] injAddr,
    output logic injReady,
    output logic coreDone,
    output logic [31:0] coreRdata
);
    logic busy_r;
    logic [3:0] wait_r;
    logic [31:0] data_r;
    // Execute or drop.
    // A reserved address is taken but dropped, so it never completes.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
            wait_r <= 4'h0;
            coreDone <= 1'b0;
            data_r <= 32'h0;
        end else begin
            coreDone <= 1'b0;
            if (injValid && injReady) begin
                busy_r <= injAddr[15:12] != 4'hF;
                wait_r <= slow ? 4'h6 : 4'h1;
                data_r <= injWrite ? 32'h0 : {16'h5A5A, injAddr};
            end else if (busy_r && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                coreDone <= 1'b1;
            end
        end
    end
    assign injReady = !busy_r;
    assign coreRdata = coreDone ? data_r : ~data_r;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic busReq = 1'b0, busFromCore = 1'b0, busWrite = 1'b0, slow = 1'b0;
    logic [31:0] busAddr = 32'h0, busWdata = 32'h0, busRdata, injWdata, coreRdata;
    logic [1:0] busAck;
    logic [15:0] injAddr;
    logic injValid, injWrite, injReady, coreDone;
    int errors = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    crsp_core_register_slave_port dut (.*);
    crsp_core_model core (.*);
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // One attempt is a single-cycle request; the answer is read one edge later.
    task automatic att(logic [31:0] a, logic w);
        @(posedge clk);
        busAddr <= a;
        busWrite <= w;
        busWdata <= ~a;
        busReq <= 1'b1;
        @(posedge clk);
        busReq <= 1'b0;
        busAddr <= ~a;
        #1;
    endtask
    task automatic t_xfer(logic [31:0] a, logic w, logic s);
        int n = 0;
        slow <= s;
        // Callers pass implemented register addresses only.
        att(a, w);
        cmp("first ack", crsp_pkg::ACK_RETRY, busAck);
        cmp("inject", 1'b1, injValid);
        cmp("inject addr", {16'h0000, a[15:0]}, {16'h0000, injAddr});
        cmp("inject dir", {31'h0, w}, {31'h0, injWrite});
        cmp("inject data", ~a, injWdata);
        repeat (20) if (busAck !== crsp_pkg::ACK_OK) begin
            att(a, w);
            n++;
        end
        cmp("retried", 1'b1, n > 1);
        cmp("final ack", crsp_pkg::ACK_OK, busAck);
        cmp("rdata", w ? 32'h0 : {16'h5A5A, a[15:0]}, busRdata);
        $display("test xfer done");
    endtask
    task automatic t_refuse();
        att(32'hF7E2_0000, 1'b0);
        cmp("above window", crsp_pkg::ACK_NONE, busAck);
        att(32'hF7E0_FFFF, 1'b0);
        cmp("below window", crsp_pkg::ACK_NONE, busAck);
        busFromCore <= 1'b1;
        att(crsp_pkg::WIN_LO, 1'b0);
        cmp("from core", crsp_pkg::ACK_NONE, busAck);
        busFromCore <= 1'b0;
        $display("test refuse done");
    endtask
    task automatic t_lock();
        repeat (8) begin
            att(crsp_pkg::WIN_HI, 1'b0);
            cmp("reserved ack", crsp_pkg::ACK_RETRY, busAck);
        end
        @(posedge clk);
        clkEn <= 1'b0;
        att(crsp_pkg::WIN_HI, 1'b0);
        cmp("frozen ack", crsp_pkg::ACK_NONE, busAck);
        clkEn <= 1'b1;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        cmp("ack in reset", crsp_pkg::ACK_NONE, busAck);
        $display("test lock done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_xfer(32'hF7E1_0104, 1'b0, 1'b0);
        t_xfer(32'hF7E1_0108, 1'b1, 1'b1);
        t_xfer(crsp_pkg::WIN_LO, 1'b0, 1'b1);
        t_refuse();
        t_lock();
        t_xfer(32'hF7E1_0104, 1'b0, 1'b0);
        conclude();
    end
    initial begin
        #500000;
        errors++;
        conclude();
    end
endmodule
